// file: core/fps_defines.svh
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH

// ************************************************************
// clock and timing
// ************************************************************
`define FPS_CLK_NS        50
`define FPS_TPSUS_NS      9400
`define FPS_TESUS_NS      16000
`define FPS_TDONES_NS     16000
`define FPS_TDRCV_MIN_NS  16000
`define FPS_TAISTOP_NS    80
`define FPS_TMRSTOP_MIN_NS 10360
// least times round up, longest times round down
`define FPS_PSUS_CYC   (16'(`FPS_TPSUS_NS / `FPS_CLK_NS) + 16'd4)
`define FPS_ESUS_CYC   (16'(`FPS_TESUS_NS / `FPS_CLK_NS) + 16'd4)
`define FPS_DONES_CYC  (16'(`FPS_TDONES_NS / `FPS_CLK_NS) + 16'd4)
`define FPS_DRCV_CYC   (16'((`FPS_TDRCV_MIN_NS + `FPS_CLK_NS - 1) \
                        / `FPS_CLK_NS) + 16'd7)
`define FPS_AISTOP_CYC (16'(`FPS_TAISTOP_NS / `FPS_CLK_NS) + 16'd15)
`define FPS_MRSTOP_CYC (16'((`FPS_TMRSTOP_MIN_NS + `FPS_CLK_NS - 1) \
                        / `FPS_CLK_NS) + 16'd4)
// length of the operations themselves
`define FPS_PROG_OP_CYC  16'd2000
`define FPS_ERASE_OP_CYC 16'd3000
`define FPS_AI_OP_CYC    16'd1000
`define FPS_MR_OP_CYC    16'd3000

// ************************************************************
// register map
// ************************************************************
`define FPS_OFS_CTRL     8'h00
`define FPS_OFS_STAT     8'h04
`define FPS_OFS_IRQ_STAT 8'h08
`define FPS_OFS_IRQ_MASK 8'h0C

// ************************************************************
// control fields
// ************************************************************
`define FPS_CTRL_HVE    0
`define FPS_CTRL_PSUS   1
`define FPS_CTRL_ESUS   2
`define FPS_CTRL_ERASE  3
`define FPS_CTRL_AIE    4
`define FPS_CTRL_INTEGRITY_CHECK_SUSPEND  5
`define FPS_CTRL_AIBPN  6
`define FPS_CTRL_AIMR   7
`define FPS_CTRL_READ_WAIT_STATE_COUNT_LO 8
`define FPS_CTRL_READ_WAIT_STATE_COUNT_HI 11
`define FPS_CTRL_APC    12
`define FPS_CTRL_LPM    16
`define FPS_CTRL_MASK   32'h0001_1FFF
`define FPS_CTRL_RST    32'h0000_0000

// ************************************************************
// status and interrupt fields
// ************************************************************
`define FPS_ST_DONE  0
`define FPS_ST_AIFIN 1
`define FPS_ST_READY 2
`define FPS_IRQ_W    3

`endif

// file: core/fps_pkg.sv
package fps_pkg;

  typedef enum logic [1:0] {
    PE_IDLE = 2'b00,
    PE_RUN  = 2'b01,
    PE_STOP = 2'b10,
    PE_SUSP = 2'b11
  } fps_pe_type;

  typedef enum logic [2:0] {
    AI_IDLE = 3'b000,
    AI_RUN  = 3'b001,
    AI_STOP = 3'b010,
    AI_HALT = 3'b011
  } fps_ai_type;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    fps_pe_type  pe_st;
    logic        pe_erase;
    logic        pe_to_susp;
    logic        done;
    fps_ai_type  ai_st;
    logic        ai_mr;
    logic        ai_to_halt;
    logic        ai_fin;
    logic        ready;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
  } fps_state_type;

  typedef struct packed {
    logic [15:0] cnt;
  } fps_tmr_state_type;

endpackage : fps_pkg

// file: core/fps_tmr_if.sv
`timescale 1ns/1ns
interface fps_tmr_if;
  logic        load;
  logic [15:0] len;
  logic        expire;
  modport ctl (output load, output len, input expire);
  modport tmr (input load, input len, output expire);
endinterface : fps_tmr_if

// file: core/fps_timer.sv
`timescale 1ns/1ns
module fps_timer (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // control
  fps_tmr_if.tmr      t
);
  import fps_pkg::*;

  fps_tmr_state_type s_r;
  fps_tmr_state_type s_nxt;

  // ************************************************************
  // countdown: expire pulses len-1 cycles after the load edge
  // ************************************************************
  always_comb begin
    s_nxt = s_r;
    if (t.load) begin
      s_nxt.cnt = t.len;
    end else if (s_r.cnt != 16'h0000) begin
      s_nxt.cnt = s_r.cnt - 16'h0001;
    end
  end

  assign t.expire = (s_r.cnt == 16'h0001) && !t.load;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : fps_timer

// file: core/fps_top.sv
// Functional notes
// RULE1: a program suspend request sets the done flag after 9.4 us plus four clocks, never later than 11.5 us plus four.
// RULE2: an erase suspend request sets the done flag after 16 us plus four clocks, never later than 20.8 us plus four.
// RULE3: clearing a suspend bit with high voltage still enabled resumes and drops the done flag within 100 ns.
// RULE4: a rising high-voltage enable starts program or erase and clears the done flag at once.
// RULE5: a falling high-voltage enable aborts the operation and sets the done flag within 20.8 us plus four clocks.
// RULE6: after low-power exit the flash is ready after 16 to 45 us plus seven clocks.
// RULE7: a rising integrity-check enable starts a check and clears the finished flag at once.
// RULE8: clearing the integrity suspend or negated breakpoint bit resumes a halted check and clears the finished flag.
// RULE9: a falling integrity-check enable aborts an array check and sets the finished flag within 80 ns plus 15 clocks.
// RULE10: an integrity suspend of an array check sets the finished flag within 80 ns plus 15 clocks.
// RULE11: a falling integrity-check enable aborts a margin read and sets the finished flag in 10.36 to 20.42 us plus four clocks.
// RULE12: an integrity suspend of a margin read sets the finished flag in 10.36 to 20.42 us plus four clocks.
// RULE13: software should use zero wait states and pipeline zero to 33 MHz, two and one to 100 MHz.
// RULE14: software should use three wait states to 133 MHz and four to 160 MHz, pipeline one.
// RULE15: both finished flags stay set while no operation is active.
`include "fps_defines.svh"
`timescale 1ns/1ns
module fps_top (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // flash controller status
  output logic             DONE,
  output logic             AI_FIN,
  output logic             FLASH_READY,
  output logic      [3:0]  FLASH_READ_WAIT_STATE_COUNT,
  output logic             FLASH_APC,
  // interrupt
  output logic             IRQ
);
  import fps_pkg::*;

  fps_state_type s_r;
  fps_state_type s_nxt;

  logic [2:0]  t_load;
  logic [15:0] t_len [3];
  logic [2:0]  t_exp;

  logic [31:0] c;
  logic        acc;
  logic        hv_rise;
  logic        hv_fall;
  logic        psus_set;
  logic        esus_set;
  logic        sus_clr;
  logic        aie_rise;
  logic        aie_fall;
  logic        integrity_check_suspend_set;
  logic        ai_resume;
  logic        lpm_rise;
  logic        lpm_fall;
  logic [2:0]  ev;
  logic [2:0]  w1c;

  // ************************************************************
  // timers: 0 program/erase, 1 integrity check, 2 recovery
  // ************************************************************
  fps_tmr_if tif [3] ();

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_tmr
      assign tif[gi].load = t_load[gi];
      assign tif[gi].len  = t_len[gi];
      assign t_exp[gi]    = tif[gi].expire;
      fps_timer u_tmr (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .t     (tif[gi])
      );
    end
  endgenerate

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_nxt  = s_r;
    t_load = 3'b000;
    for (int i = 0; i < 3; i++) begin
      t_len[i] = 16'h0000;
    end
    acc = HSEL && HTRANS[1] && HREADY;
    w1c = 3'b000;

    // bus data phase write
    c = s_r.ctrl;
    if (s_r.wr_pend && s_r.wr_addr == `FPS_OFS_CTRL) begin
      c = HWDATA & `FPS_CTRL_MASK;
    end
    if (s_r.wr_pend && s_r.wr_addr == `FPS_OFS_IRQ_MASK) begin
      s_nxt.irq_mask = HWDATA[`FPS_IRQ_W-1:0];
    end
    if (s_r.wr_pend && s_r.wr_addr == `FPS_OFS_IRQ_STAT) begin
      w1c = HWDATA[`FPS_IRQ_W-1:0];
    end
    s_nxt.ctrl = c;

    // control bit transitions seen this write
    hv_rise   = !s_r.ctrl[`FPS_CTRL_HVE] && c[`FPS_CTRL_HVE];
    hv_fall   = s_r.ctrl[`FPS_CTRL_HVE] && !c[`FPS_CTRL_HVE];
    psus_set  = !s_r.ctrl[`FPS_CTRL_PSUS] && c[`FPS_CTRL_PSUS];
    esus_set  = !s_r.ctrl[`FPS_CTRL_ESUS] && c[`FPS_CTRL_ESUS];
    sus_clr   = (s_r.ctrl[`FPS_CTRL_PSUS] && !c[`FPS_CTRL_PSUS])
             || (s_r.ctrl[`FPS_CTRL_ESUS] && !c[`FPS_CTRL_ESUS]);
    aie_rise  = !s_r.ctrl[`FPS_CTRL_AIE] && c[`FPS_CTRL_AIE];
    aie_fall  = s_r.ctrl[`FPS_CTRL_AIE] && !c[`FPS_CTRL_AIE];
    integrity_check_suspend_set = !s_r.ctrl[`FPS_CTRL_INTEGRITY_CHECK_SUSPEND] && c[`FPS_CTRL_INTEGRITY_CHECK_SUSPEND];
    ai_resume = (s_r.ctrl[`FPS_CTRL_INTEGRITY_CHECK_SUSPEND] && !c[`FPS_CTRL_INTEGRITY_CHECK_SUSPEND])
             || (s_r.ctrl[`FPS_CTRL_AIBPN] && !c[`FPS_CTRL_AIBPN]);
    lpm_rise  = !s_r.ctrl[`FPS_CTRL_LPM] && c[`FPS_CTRL_LPM];
    lpm_fall  = s_r.ctrl[`FPS_CTRL_LPM] && !c[`FPS_CTRL_LPM];

    // ************************************************************
    // program / erase sequencer
    // ************************************************************
    unique case (s_r.pe_st)
      PE_IDLE: begin
        // RULE4 start clears done
        if (hv_rise) begin
          s_nxt.pe_st    = PE_RUN;
          s_nxt.pe_erase = c[`FPS_CTRL_ERASE];
          s_nxt.done     = 1'b0;
          t_load[0]      = 1'b1;
          t_len[0]       = c[`FPS_CTRL_ERASE] ? `FPS_ERASE_OP_CYC
                                              : `FPS_PROG_OP_CYC;
        end
      end
      PE_RUN: begin
        if (hv_fall) begin
          // RULE5 abort timing
          s_nxt.pe_st      = PE_STOP;
          s_nxt.pe_to_susp = 1'b0;
          t_load[0]        = 1'b1;
          t_len[0]         = `FPS_DONES_CYC;
        end else if (psus_set && !s_r.pe_erase) begin
          // RULE1 program suspend time
          s_nxt.pe_st      = PE_STOP;
          s_nxt.pe_to_susp = 1'b1;
          t_load[0]        = 1'b1;
          t_len[0]         = `FPS_PSUS_CYC;
        end else if (esus_set && s_r.pe_erase) begin
          // RULE2 erase suspend time
          s_nxt.pe_st      = PE_STOP;
          s_nxt.pe_to_susp = 1'b1;
          t_load[0]        = 1'b1;
          t_len[0]         = `FPS_ESUS_CYC;
        end else if (t_exp[0]) begin
          // RULE15 done held when idle
          s_nxt.pe_st = PE_IDLE;
          s_nxt.done  = 1'b1;
        end
      end
      PE_STOP: begin
        if (hv_fall) begin
          s_nxt.pe_to_susp = 1'b0;
        end
        if (t_exp[0]) begin
          s_nxt.pe_st = (s_r.pe_to_susp && !hv_fall) ? PE_SUSP : PE_IDLE;
          s_nxt.done  = 1'b1;
        end
      end
      PE_SUSP: begin
        if (!c[`FPS_CTRL_HVE]) begin
          s_nxt.pe_st = PE_IDLE;
        end else if (sus_clr) begin
          // RULE3 resume drops done
          s_nxt.pe_st = PE_RUN;
          s_nxt.done  = 1'b0;
          t_load[0]   = 1'b1;
          t_len[0]    = s_r.pe_erase ? `FPS_ERASE_OP_CYC
                                     : `FPS_PROG_OP_CYC;
        end
      end
    endcase

    // ************************************************************
    // array integrity / margin read sequencer
    // ************************************************************
    unique case (s_r.ai_st)
      AI_IDLE: begin
        // RULE7 start clears finished
        if (aie_rise) begin
          s_nxt.ai_st  = AI_RUN;
          s_nxt.ai_mr  = c[`FPS_CTRL_AIMR];
          s_nxt.ai_fin = 1'b0;
          t_load[1]    = 1'b1;
          t_len[1]     = c[`FPS_CTRL_AIMR] ? `FPS_MR_OP_CYC
                                           : `FPS_AI_OP_CYC;
        end
      end
      AI_RUN: begin
        if (aie_fall || integrity_check_suspend_set) begin
          // RULE9 RULE11 abort timing
          // RULE10 RULE12 suspend timing
          s_nxt.ai_st      = AI_STOP;
          s_nxt.ai_to_halt = !aie_fall;
          t_load[1]        = 1'b1;
          t_len[1]         = s_r.ai_mr ? `FPS_MRSTOP_CYC
                                       : `FPS_AISTOP_CYC;
        end else if (t_exp[1]) begin
          // RULE15 finished held when idle
          s_nxt.ai_st  = AI_IDLE;
          s_nxt.ai_fin = 1'b1;
        end
      end
      AI_STOP: begin
        if (aie_fall) begin
          s_nxt.ai_to_halt = 1'b0;
        end
        if (t_exp[1]) begin
          s_nxt.ai_st  = (s_r.ai_to_halt && !aie_fall) ? AI_HALT
                                                       : AI_IDLE;
          s_nxt.ai_fin = 1'b1;
        end
      end
      AI_HALT: begin
        if (!c[`FPS_CTRL_AIE]) begin
          s_nxt.ai_st = AI_IDLE;
        end else if (ai_resume) begin
          // RULE8 resume clears finished
          s_nxt.ai_st  = AI_RUN;
          s_nxt.ai_fin = 1'b0;
          t_load[1]    = 1'b1;
          t_len[1]     = s_r.ai_mr ? `FPS_MR_OP_CYC : `FPS_AI_OP_CYC;
        end
      end
      default: begin
        s_nxt.ai_st  = AI_IDLE;
        s_nxt.ai_fin = 1'b1;
      end
    endcase

    // ************************************************************
    // low-power recovery
    // ************************************************************
    if (lpm_rise) begin
      s_nxt.ready = 1'b0;
    end
    // RULE6 recovery after exit
    if (lpm_fall) begin
      t_load[2] = 1'b1;
      t_len[2]  = `FPS_DRCV_CYC;
    end else if (t_exp[2] && !c[`FPS_CTRL_LPM]) begin
      s_nxt.ready = 1'b1;
    end

    // ************************************************************
    // interrupts: rising flags are sticky, set beats clear
    // ************************************************************
    ev[`FPS_ST_DONE]  = s_nxt.done && !s_r.done;
    ev[`FPS_ST_AIFIN] = s_nxt.ai_fin && !s_r.ai_fin;
    ev[`FPS_ST_READY] = s_nxt.ready && !s_r.ready;
    s_nxt.irq_stat    = (s_r.irq_stat & ~w1c) | ev;

    // ************************************************************
    // bus address phase and read data
    // ************************************************************
    s_nxt.wr_pend = acc && HWRITE;
    s_nxt.wr_addr = HADDR[7:0];
    if (acc && !HWRITE) begin
      unique case (HADDR[7:0])
        `FPS_OFS_CTRL: begin
          s_nxt.rdata = s_nxt.ctrl;
        end
        `FPS_OFS_STAT: begin
          s_nxt.rdata = {29'h0000_0000, s_nxt.ready, s_nxt.ai_fin,
                         s_nxt.done};
        end
        `FPS_OFS_IRQ_STAT: begin
          s_nxt.rdata = {29'h0000_0000, s_nxt.irq_stat};
        end
        `FPS_OFS_IRQ_MASK: begin
          s_nxt.rdata = {29'h0000_0000, s_nxt.irq_mask};
        end
        default: begin
          s_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      s_r        <= '0;
      s_r.ctrl   <= `FPS_CTRL_RST;
      s_r.done   <= 1'b1;
      s_r.ai_fin <= 1'b1;
      s_r.ready  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign HRDATA      = s_r.rdata;
  assign HREADYOUT   = 1'b1;
  assign HRESP       = 1'b0;
  assign DONE        = s_r.done;
  assign AI_FIN      = s_r.ai_fin;
  assign FLASH_READY = s_r.ready;
  // RULE13 RULE14 wait state settings
  assign FLASH_READ_WAIT_STATE_COUNT  = s_r.ctrl[`FPS_CTRL_READ_WAIT_STATE_COUNT_HI:`FPS_CTRL_READ_WAIT_STATE_COUNT_LO];
  assign FLASH_APC   = s_r.ctrl[`FPS_CTRL_APC];
  assign IRQ         = |(s_r.irq_stat & s_r.irq_mask);

endmodule : fps_top

// file: tb/fps_assertions.sv
`timescale 1ns/1ns
module fps_chk (
  // clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  // bus
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  // status
  input wire logic        DONE,
  input wire logic        AI_FIN,
  input wire logic        FLASH_READY
);
  // ****************
  // control shadow
  // ****************
  logic        wph_r;
  logic [16:0] old_r;
  logic        ers_r;
  logic        mr_r;
  logic        psh_r;
  logic        aih_r;
  logic        wr;
  logic [16:0] nw;
  logic        hv_up;
  logic        hv_dn;
  logic        ps_set;
  logic        es_set;
  logic        pe_res;
  logic        pe_go;
  logic        ai_up;
  logic        ai_stop;
  logic        ai_res;
  logic        ai_go;
  logic        lp_dn;
  assign wr      = wph_r & HREADY;
  assign nw      = HWDATA[16:0];
  assign hv_up   = wr & !old_r[0] & nw[0];
  assign hv_dn   = wr & old_r[0] & !nw[0] & !DONE;
  assign ps_set  = wr & !old_r[1] & nw[1] & nw[0] & !DONE & !ers_r;
  assign es_set  = wr & !old_r[2] & nw[2] & nw[0] & !DONE & ers_r;
  assign pe_res  = wr & psh_r & nw[0]
                 & (old_r[1] & !nw[1] | old_r[2] & !nw[2]);
  assign pe_go   = hv_up | pe_res;
  assign ai_up   = wr & !old_r[4] & nw[4];
  assign ai_stop = wr & !AI_FIN & (old_r[4] & !nw[4] | !old_r[5] & nw[5]);
  assign ai_res  = wr & aih_r & nw[4]
                 & (old_r[5] & !nw[5] | old_r[6] & !nw[6]);
  assign ai_go   = ai_up | ai_res;
  assign lp_dn   = wr & old_r[16] & !nw[16];
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      wph_r <= 1'b0;
      old_r <= '0;
      ers_r <= 1'b0;
      mr_r  <= 1'b0;
      psh_r <= 1'b0;
      aih_r <= 1'b0;
    end else begin
      wph_r <= HSEL & HTRANS[1] & HREADY & HWRITE & (HADDR[7:0] == 8'h00);
      if (wr) begin
        old_r <= nw;
        psh_r <= ps_set | es_set;
        aih_r <= ai_stop & nw[5] & nw[4];
      end
      if (hv_up)
        ers_r <= nw[3];
      if (ai_up)
        mr_r <= nw[7];
    end
  end
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  prog_susp_a: assert property (ps_set |-> ##[1:235] DONE)
    else $error("program suspend late");
  erase_susp_a: assert property (es_set |-> ##[1:421] DONE)
    else $error("erase suspend late");
  pe_resume_a: assert property (pe_res |-> ##[1:2] !DONE)
    else $error("resume did not clear done");
  hv_start_a: assert property (hv_up |=> !DONE)
    else $error("start did not clear done");
  hv_abort_a: assert property (hv_dn |-> ##[1:421] DONE)
    else $error("abort late");
  lp_recover_a: assert property
    (lp_dn |-> ##[328:908] $rose(FLASH_READY))
    else $error("recovery out of range");
  ai_start_a: assert property (ai_up |=> !AI_FIN)
    else $error("check start did not clear flag");
  ai_resume_a: assert property (ai_res |=> !AI_FIN)
    else $error("check resume did not clear flag");
  ai_stop_a: assert property
    (ai_stop & !mr_r |-> ##[1:17] AI_FIN)
    else $error("array stop late");
  mr_stop_a: assert property
    (ai_stop & mr_r |-> ##[213:413] $rose(AI_FIN))
    else $error("margin stop out of range");
  done_hold_a: assert property ($fell(DONE) |-> $past(pe_go))
    else $error("done dropped while idle");
  fin_hold_a: assert property ($fell(AI_FIN) |-> $past(ai_go))
    else $error("finished dropped while idle");
endmodule : fps_chk

// file: tb/fps_top_tb.sv
`timescale 1ns/1ns
module fps_top_tb;
  logic        sys_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        done;
  logic        ai_fin;
  logic        flash_ready;
  logic [3:0]  flash_read_wait_state_count;
  logic        flash_apc;
  logic        irq;
  int          err_count;
  int          n_checks;

  fps_top i_fps_top (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .DONE(done), .AI_FIN(ai_fin),
    .FLASH_READY(flash_ready), .FLASH_READ_WAIT_STATE_COUNT(flash_read_wait_state_count),
    .FLASH_APC(flash_apc), .IRQ(irq)
  );

  // ****************
  // bus and compare
  // ****************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task chk_rng(input int n, input int lo, input int hi);
    n_checks++;
    if (n < lo || n > hi) begin
      err_count++;
      $display("wrong value at %0t: delay %0d cycles", $time, n);
    end
  endtask : chk_rng
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d,
           output logic [31:0] q);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
    #1;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask : rd
  function automatic logic flag(input int s);
    return (s == 0) ? done : (s == 1) ? ai_fin : flash_ready;
  endfunction : flag
  task wt(input int s, input int lo, input int hi);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (flag(s) !== 1'b1 && n < 5000);
    chk_rng(n, lo, hi);
  endtask : wt
  function automatic logic [31:0] pins();
    return {22'h0, done, ai_fin, flash_ready, flash_apc, irq, hresp,
            flash_read_wait_state_count};
  endfunction : pins

  // ****************
  // scenarios
  // ****************
  task t_reset;
    chk(pins(), 32'h0000_0380);
    chk(hreadyout, 32'h1);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h7);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task t_prog;
    wr(8'h00, 32'h1);
    chk(done, 32'h0);
    wr(8'h00, 32'h3);
    wt(0, 1, 234);
    wr(8'h00, 32'h1);
    chk(done, 32'h0);
    wt(0, 1, 2100);
    repeat (20) @(posedge sys_clk);
    chk(done, 32'h1);
    wr(8'h00, 32'h0);
    chk(done, 32'h1);
    $display("program test done");
  endtask : t_prog
  task t_erase;
    wr(8'h00, 32'h8);
    wr(8'h00, 32'h9);
    chk(done, 32'h0);
    wr(8'h00, 32'hD);
    wt(0, 1, 420);
    wr(8'h00, 32'h9);
    chk(done, 32'h0);
    wr(8'h00, 32'h8);
    wt(0, 1, 420);
    rd(8'h04, 32'h7);
    $display("erase test done");
  endtask : t_erase
  task t_array;
    wr(8'h00, 32'h10);
    chk(ai_fin, 32'h0);
    wr(8'h00, 32'h30);
    wt(1, 1, 16);
    wr(8'h00, 32'h10);
    chk(ai_fin, 32'h0);
    wr(8'h00, 32'h0);
    wt(1, 1, 16);
    wr(8'h00, 32'h50);
    wr(8'h00, 32'h70);
    wt(1, 1, 16);
    wr(8'h00, 32'h30);
    chk(ai_fin, 32'h0);
    wr(8'h00, 32'h0);
    wt(1, 1, 16);
    $display("array test done");
  endtask : t_array
  task t_margin;
    wr(8'h00, 32'h80);
    wr(8'h00, 32'h90);
    chk(ai_fin, 32'h0);
    wr(8'h00, 32'hB0);
    wt(1, 212, 412);
    wr(8'h00, 32'h90);
    chk(ai_fin, 32'h0);
    wr(8'h00, 32'h80);
    wt(1, 212, 412);
    $display("margin test done");
  endtask : t_margin
  task t_power;
    logic [3:0] w;
    logic       a;
    wr(8'h00, 32'h0001_0000);
    chk(flash_ready, 32'h0);
    wr(8'h00, 32'h0);
    wt(2, 327, 907);
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 4'h0 : 4'(i + 1);
      a = (i != 0);
      wr(8'h00, {19'h0, a, w, 8'h0});
      chk(pins(), {22'h0, 3'h7, a, 2'h0, w});
      rd(8'h00, {19'h0, a, w, 8'h0});
    end
    $display("power test done");
  endtask : t_power
  task t_irq;
    wr(8'h08, 32'h7);
    rd(8'h08, 32'h0);
    wr(8'h00, 32'h10);
    wr(8'h00, 32'h0);
    wt(1, 1, 16);
    rd(8'h08, 32'h2);
    chk(irq, 32'h0);
    wr(8'h0C, 32'h2);
    chk(irq, 32'h1);
    rd(8'h0C, 32'h2);
    wr(8'h08, 32'h2);
    chk(irq, 32'h0);
    rd(8'h08, 32'h0);
    $display("interrupt test done");
  endtask : t_irq

  // ****************
  // run
  // ****************
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #2000000;
    err_count++;
    print_verdict();
  end
  initial begin
    err_count = 0;
    n_checks  = 0;
    rst_n     = 1'b0;
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hwdata    = 32'h0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_prog();
    t_erase();
    t_array();
    t_margin();
    t_power();
    t_irq();
    print_verdict();
  end
endmodule : fps_top_tb

bind fps_top fps_chk i_fps_chk (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .DONE(DONE), .AI_FIN(AI_FIN), .FLASH_READY(FLASH_READY)
);
